// ---- design/scan_regs_pkg.sv ----
// Operation
// - Boundary chain has eighteen cells, one per pin
// - Active instruction picks chain capture source
// - Idle state changes chain only per instruction
// - Test-logic reset leaves chain contents alone
// - Chain shifts from input through 17..0 out
// - Cells map clock, enable, inputs, outputs
// - Two-bit select register picks run-test operation
// - Select register unchanged at data capture
// - Reset loads select register with binary 10
// - Single-stage bypass between serial input and output
// - Bypass stage captures zero when selected
// - Instruction MSB ignored, low seven bits decode
// - Decode chain opcodes with their modes
// - Run-test and toggle bypass; select scans decoded
// - Opcode 0000110 floats outputs, bypass selected
// - Opcode 0000111 clamps pins, bypass selected
// - Undefined opcodes act as normal-mode bypass
// - Boundary scan captures input pins, core outputs
// - Test mode drives core and pins from cells
// - Eight-bit instruction selects mode, register, source
// - Instruction register resets to all ones
// - Instruction capture loads fixed 10000001
// - Select codes: toggle, pattern, signature, both
package scan_regs_pkg;

	localparam int          CHAIN_LEN  = 18;
	localparam int          IR_LEN     = 8;
	localparam int          OPSEL_LEN  = 2;
	localparam int          CELL_CLK   = 17;
	localparam int          CELL_OE    = 16;
	localparam logic [7:0]  IR_RESET   = 8'hff;
	localparam logic [7:0]  IR_CAPTURE = 8'h81;
	localparam logic [1:0]  OPSEL_RESET = 2'b10;

	// Operations held in the select register
	localparam logic [1:0]  OPS_SAMPLE_IN_TOGGLE_OUT = 2'b00;
	localparam logic [1:0]  OPS_PATTERN_GENERATE     = 2'b01;
	localparam logic [1:0]  OPS_SIGNATURE_COMPRESS   = 2'b10;
	localparam logic [1:0]  OPS_COMBINED_8BIT        = 2'b11;

	// Opcodes, low seven bits
	localparam logic [6:0]  OP_EXTEST_A          = 7'h00;
	localparam logic [6:0]  OP_SAMPLE            = 7'h02;
	localparam logic [6:0]  OP_EXTEST_B          = 7'h03;
	localparam logic [6:0]  OP_FLOAT_OUTPUTS     = 7'h06;
	localparam logic [6:0]  OP_PIN_CLAMP         = 7'h07;
	localparam logic [6:0]  OP_RUN_TEST          = 7'h09;
	localparam logic [6:0]  OP_CHAIN_READ_NORMAL = 7'h0a;
	localparam logic [6:0]  OP_CHAIN_READ_TEST   = 7'h0b;
	localparam logic [6:0]  OP_CELL_SELF_CHECK   = 7'h0c;
	localparam logic [6:0]  OP_OUTPUT_TOGGLE     = 7'h0d;
	localparam logic [6:0]  OP_OPSEL_SCAN_NORMAL = 7'h0e;
	localparam logic [6:0]  OP_OPSEL_SCAN_TEST   = 7'h0f;

	// Register bus map
	localparam int          AXI_ADDR_W     = 8;
	localparam logic [7:0]  ADDR_CTRL      = 8'h00;
	localparam logic [7:0]  ADDR_STATUS    = 8'h04;
	localparam logic [7:0]  ADDR_CHAIN_SHF = 8'h08;
	localparam logic [7:0]  ADDR_CHAIN_SHD = 8'h0c;
	localparam logic [1:0]  RESP_OKAY      = 2'b00;
	localparam logic [1:0]  RESP_SLVERR    = 2'b10;

	typedef enum logic [15:0] {
		TAP_RESET = 16'h0001, TAP_IDLE    = 16'h0002, TAP_SEL_DR = 16'h0004,
		TAP_CAP_DR = 16'h0008, TAP_SHF_DR = 16'h0010, TAP_EX1_DR = 16'h0020,
		TAP_PAU_DR = 16'h0040, TAP_EX2_DR = 16'h0080, TAP_UPD_DR = 16'h0100,
		TAP_SEL_IR = 16'h0200, TAP_CAP_IR = 16'h0400, TAP_SHF_IR = 16'h0800,
		TAP_EX1_IR = 16'h1000, TAP_PAU_IR = 16'h2000, TAP_EX2_IR = 16'h4000,
		TAP_UPD_IR = 16'h8000
	} tap_state_e;

	typedef enum logic [1:0] {SEL_BYPASS, SEL_CHAIN, SEL_OPSEL} dr_sel_e;
	typedef enum logic [1:0] {CAP_PINS, CAP_HOLD, CAP_INVERT} cap_src_e;

	typedef struct packed {
		dr_sel_e  sel;
		cap_src_e cap;
		logic     test;
		logic     hiz;
		logic     run_test;
		logic     toggle;
	} instr_dec_s;

	// Opcode decode; unlisted codes fall to normal-mode bypass
	function automatic instr_dec_s decode_instr(input logic [6:0] op);
		instr_dec_s d;
		d = '{sel: SEL_BYPASS, cap: CAP_PINS, test: 1'b0, hiz: 1'b0,
			run_test: 1'b0, toggle: 1'b0};
		case (op)
			OP_EXTEST_A, OP_EXTEST_B: begin
				d.sel  = SEL_CHAIN;
				d.test = 1'b1;
			end
			OP_SAMPLE:            d.sel = SEL_CHAIN;
			OP_FLOAT_OUTPUTS:     d.hiz = 1'b1;
			OP_PIN_CLAMP:         d.test = 1'b1;
			OP_RUN_TEST: begin
				d.test     = 1'b1;
				d.run_test = 1'b1;
			end
			OP_CHAIN_READ_NORMAL, OP_CHAIN_READ_TEST: begin
				d.sel  = SEL_CHAIN;
				d.cap  = CAP_HOLD;
				d.test = op[0];
			end
			OP_CELL_SELF_CHECK: begin
				d.sel = SEL_CHAIN;
				d.cap = CAP_INVERT;
			end
			OP_OUTPUT_TOGGLE: begin
				d.test   = 1'b1;
				d.toggle = 1'b1;
			end
			OP_OPSEL_SCAN_NORMAL, OP_OPSEL_SCAN_TEST: begin
				d.sel  = SEL_OPSEL;
				d.test = op[0];
			end
			default: ;
		endcase
		return d;
	endfunction

endpackage

// ---- design/octal_ff_boundary_scan_regs.sv ----
`timescale 1ns/1ps
module octal_ff_boundary_scan_regs
	import scan_regs_pkg::*;
#(
	parameter logic [15:0] TAPS16 = 16'hb400, // Wide feedback taps
	parameter logic [7:0]  TAPS8  = 8'hb8     // Narrow feedback taps
) (
	input  logic                  ref_clk,       // System clock
	input  logic                  rst_n,         // Async reset, low
	input  logic                  tck,           // Test clock pin
	input  logic                  tms,           // Test mode select pin
	input  logic                  tdi,           // Serial test input
	output logic                  tdo,           // Serial test output
	output logic                  tdo_oe,        // Serial output enable
	input  logic                  pin_clk,       // Flip-flop clock pin
	input  logic                  pin_oe_n,      // Output enable pin
	input  logic [7:0]            pin_d,         // Data input pins
	input  logic [7:0]            core_q,        // Core flop outputs
	output logic                  core_clk,      // Clock to core
	output logic                  core_oe_n,     // Enable to core
	output logic [7:0]            core_d,        // Data to core
	output logic [7:0]            pin_q,         // Output pin data
	output logic                  pin_q_oe,      // Output pin enable
	input  logic [AXI_ADDR_W-1:0] s_axi_awaddr,  // Write address
	input  logic                  s_axi_awvalid, // Write addr valid
	output logic                  s_axi_awready, // Write addr ready
	input  logic [31:0]           s_axi_wdata,   // Write data
	input  logic [3:0]            s_axi_wstrb,   // Write strobes
	input  logic                  s_axi_wvalid,  // Write data valid
	output logic                  s_axi_wready,  // Write data ready
	output logic [1:0]            s_axi_bresp,   // Write response
	output logic                  s_axi_bvalid,  // Write resp valid
	input  logic                  s_axi_bready,  // Write resp ready
	input  logic [AXI_ADDR_W-1:0] s_axi_araddr,  // Read address
	input  logic                  s_axi_arvalid, // Read addr valid
	output logic                  s_axi_arready, // Read addr ready
	output logic [31:0]           s_axi_rdata,   // Read data
	output logic [1:0]            s_axi_rresp,   // Read response
	output logic                  s_axi_rvalid,  // Read data valid
	input  logic                  s_axi_rready   // Read data ready
);

////////////////////////////////////////////////////////////////////////////////
	logic [2:0]           tck_sync_ff;
	logic [1:0]           tms_sync_ff;
	logic [1:0]           tdi_sync_ff;
	logic [9:0]           pin_sync1_ff;
	logic [9:0]           pin_sync2_ff;
	logic                 tck_rise;
	logic                 tck_fall;
	logic                 tms_s;
	logic                 tdi_s;
	logic                 clk_s;
	logic                 oe_n_s;
	logic [7:0]           d_s;
	tap_state_e           state_ff;
	tap_state_e           nxt_state;
	logic                 trst_ff;
	logic [IR_LEN-1:0]    ir_shift_ff;
	logic [IR_LEN-1:0]    ir_ff;
	instr_dec_s           dec;
	logic                 bypass_ff;
	logic [OPSEL_LEN-1:0] opsel_shift_ff;
	logic [OPSEL_LEN-1:0] opsel_ff;
	logic [CHAIN_LEN-1:0] chain_shift_ff;
	logic [CHAIN_LEN-1:0] chain_ff;
	logic [CHAIN_LEN-1:0] cap_val;
	logic [15:0]          run_val;
	logic [15:0]          run_mask;
	logic [15:0]          wide_step;
	logic [7:0]           in_step;
	logic [7:0]           out_step;
	logic                 rise_cap_dr;
	logic                 rise_shf_dr;
	logic                 rise_idle;
	logic                 fall_idle;
	logic                 dr_lsb;

	// Two flops on every outside level; third tck flop only finds edges
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			tck_sync_ff  <= 3'b000;
			tms_sync_ff  <= 2'b11;
			tdi_sync_ff  <= 2'b00;
			pin_sync1_ff <= 10'h000;
			pin_sync2_ff <= 10'h000;
		end else begin
			tck_sync_ff  <= {tck_sync_ff[1:0], tck};
			tms_sync_ff  <= {tms_sync_ff[0], tms};
			tdi_sync_ff  <= {tdi_sync_ff[0], tdi};
			pin_sync1_ff <= {pin_clk, pin_oe_n, pin_d};
			pin_sync2_ff <= pin_sync1_ff;
		end
	end

	// Edge finding and synced pin fields
	assign tck_rise = tck_sync_ff[1] & ~tck_sync_ff[2];
	assign tck_fall = ~tck_sync_ff[1] & tck_sync_ff[2];
	assign tms_s    = tms_sync_ff[1];
	assign tdi_s    = tdi_sync_ff[1];
	assign clk_s    = pin_sync2_ff[9];
	assign oe_n_s   = pin_sync2_ff[8];
	assign d_s      = pin_sync2_ff[7:0];

////////////////////////////////////////////////////////////////////////////////
	// Controller sequencing, needed to know capture, shift and update steps
	always_comb begin
		case (state_ff)
			TAP_RESET:  nxt_state = tms_s ? TAP_RESET  : TAP_IDLE;
			TAP_IDLE:   nxt_state = tms_s ? TAP_SEL_DR : TAP_IDLE;
			TAP_SEL_DR: nxt_state = tms_s ? TAP_SEL_IR : TAP_CAP_DR;
			TAP_CAP_DR: nxt_state = tms_s ? TAP_EX1_DR : TAP_SHF_DR;
			TAP_SHF_DR: nxt_state = tms_s ? TAP_EX1_DR : TAP_SHF_DR;
			TAP_EX1_DR: nxt_state = tms_s ? TAP_UPD_DR : TAP_PAU_DR;
			TAP_PAU_DR: nxt_state = tms_s ? TAP_EX2_DR : TAP_PAU_DR;
			TAP_EX2_DR: nxt_state = tms_s ? TAP_UPD_DR : TAP_SHF_DR;
			TAP_UPD_DR: nxt_state = tms_s ? TAP_SEL_DR : TAP_IDLE;
			TAP_SEL_IR: nxt_state = tms_s ? TAP_RESET  : TAP_CAP_IR;
			TAP_CAP_IR: nxt_state = tms_s ? TAP_EX1_IR : TAP_SHF_IR;
			TAP_SHF_IR: nxt_state = tms_s ? TAP_EX1_IR : TAP_SHF_IR;
			TAP_EX1_IR: nxt_state = tms_s ? TAP_UPD_IR : TAP_PAU_IR;
			TAP_PAU_IR: nxt_state = tms_s ? TAP_EX2_IR : TAP_PAU_IR;
			TAP_EX2_IR: nxt_state = tms_s ? TAP_UPD_IR : TAP_SHF_IR;
			TAP_UPD_IR: nxt_state = tms_s ? TAP_SEL_DR : TAP_IDLE;
			default:    nxt_state = TAP_RESET;
		endcase
	end

	// Software reset bit holds the controller in reset
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n)
			state_ff <= TAP_RESET;
		else if (trst_ff)
			state_ff <= TAP_RESET;
		else if (tck_rise)
			state_ff <= nxt_state;
	end

////////////////////////////////////////////////////////////////////////////////
	// Instruction register: fixed capture, LSB first out, update on fall
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			ir_shift_ff <= IR_RESET;
			ir_ff       <= IR_RESET;
		end else if (state_ff == TAP_RESET) begin
			ir_ff <= IR_RESET;
		end else if (tck_rise && state_ff == TAP_CAP_IR) begin
			ir_shift_ff <= IR_CAPTURE;
		end else if (tck_rise && state_ff == TAP_SHF_IR) begin
			ir_shift_ff <= {tdi_s, ir_shift_ff[IR_LEN-1:1]};
		end else if (tck_fall && state_ff == TAP_UPD_IR) begin
			ir_ff <= ir_shift_ff;
		end
	end

	// Only the low seven bits decide mode, register and source
	assign dec = decode_instr(ir_ff[6:0]);

	// Step conditions on test clock edges
	assign rise_cap_dr = tck_rise && state_ff == TAP_CAP_DR;
	assign rise_shf_dr = tck_rise && state_ff == TAP_SHF_DR;
	assign rise_idle   = tck_rise && state_ff == TAP_IDLE;
	assign fall_idle   = tck_fall && state_ff == TAP_IDLE;

////////////////////////////////////////////////////////////////////////////////
	// Bypass stage: zero at capture, one flop of shift, no shadow
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n)
			bypass_ff <= 1'b0;
		else if (rise_cap_dr && dec.sel == SEL_BYPASS)
			bypass_ff <= 1'b0;
		else if (rise_shf_dr && dec.sel == SEL_BYPASS)
			bypass_ff <= tdi_s;
	end

	// Select register ignores capture; reset loads signature mode
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			opsel_shift_ff <= OPSEL_RESET;
			opsel_ff       <= OPSEL_RESET;
		end else if (state_ff == TAP_RESET) begin
			opsel_shift_ff <= OPSEL_RESET;
			opsel_ff       <= OPSEL_RESET;
		end else if (rise_shf_dr && dec.sel == SEL_OPSEL) begin
			opsel_shift_ff <= {tdi_s, opsel_shift_ff[OPSEL_LEN-1:1]};
		end else if (tck_fall && state_ff == TAP_UPD_DR && dec.sel == SEL_OPSEL) begin
			opsel_ff <= opsel_shift_ff;
		end
	end

////////////////////////////////////////////////////////////////////////////////
	// Capture source; cells 17..0 are clk, oe, d, q, pin one on bit 7
	assign cap_val = (dec.cap == CAP_HOLD)   ? chain_shift_ff :
	                 (dec.cap == CAP_INVERT) ? ~chain_ff :
	                 {clk_s, oe_n_s, d_s, core_q};

	// Feedback steps for the run-test compressors and generators
	assign wide_step = {chain_shift_ff[14:0], ^(chain_shift_ff[15:0] & TAPS16)};
	assign in_step   = {chain_shift_ff[14:8], ^(chain_shift_ff[15:8] & TAPS8)};
	assign out_step  = {chain_shift_ff[6:0], ^(chain_shift_ff[7:0] & TAPS8)};

	// Run-test value and which shadows follow it; control cells excluded
	always_comb begin
		case (opsel_ff)
			OPS_SAMPLE_IN_TOGGLE_OUT: begin
				run_val  = {d_s, ~chain_shift_ff[7:0]};
				run_mask = 16'hffff;
			end
			OPS_PATTERN_GENERATE: begin
				run_val  = wide_step;
				run_mask = 16'hffff;
			end
			OPS_SIGNATURE_COMPRESS: begin
				run_val  = wide_step ^ {d_s, 8'h00};
				run_mask = 16'hff00;
			end
			default: begin
				run_val  = {in_step ^ d_s, out_step};
				run_mask = 16'hffff;
			end
		endcase
		if (dec.toggle) begin
			run_val  = {chain_shift_ff[15:8], ~chain_shift_ff[7:0]};
			run_mask = 16'h00ff;
		end
	end

	// Chain shift stage: capture, shift 17 toward 0, idle-time activity
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n)
			chain_shift_ff <= '0;
		else if (rise_cap_dr && dec.sel == SEL_CHAIN)
			chain_shift_ff <= cap_val;
		else if (rise_shf_dr && dec.sel == SEL_CHAIN)
			chain_shift_ff <= {tdi_s, chain_shift_ff[CHAIN_LEN-1:1]};
		else if (rise_idle && (dec.run_test || dec.toggle))
			chain_shift_ff[15:0] <= run_val;
	end

	// Chain shadows: update step, or masked follow during idle activity
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n)
			chain_ff <= '0;
		else if (tck_fall && state_ff == TAP_UPD_DR && dec.sel == SEL_CHAIN)
			chain_ff <= chain_shift_ff;
		else if (fall_idle && (dec.run_test || dec.toggle))
			chain_ff[15:0] <= (chain_shift_ff[15:0] & run_mask)
				| (chain_ff[15:0] & ~run_mask);
	end

////////////////////////////////////////////////////////////////////////////////
	// Serial output changes on the falling test clock edge
	assign dr_lsb = (dec.sel == SEL_CHAIN) ? chain_shift_ff[0] :
	                (dec.sel == SEL_OPSEL) ? opsel_shift_ff[0] : bypass_ff;

	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			tdo    <= 1'b0;
			tdo_oe <= 1'b0;
		end else if (tck_fall) begin
			tdo    <= (state_ff == TAP_SHF_IR) ? ir_shift_ff[0] : dr_lsb;
			tdo_oe <= state_ff == TAP_SHF_IR || state_ff == TAP_SHF_DR;
		end
	end

	// Pin and core drive; floating mode keeps core running normally
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			core_clk  <= 1'b0;
			core_oe_n <= 1'b1;
			core_d    <= 8'h00;
			pin_q     <= 8'h00;
			pin_q_oe  <= 1'b0;
		end else if (dec.test) begin
			core_clk  <= chain_ff[CELL_CLK];
			core_oe_n <= chain_ff[CELL_OE];
			core_d    <= chain_ff[15:8];
			pin_q     <= chain_ff[7:0];
			pin_q_oe  <= ~chain_ff[CELL_OE];
		end else begin
			core_clk  <= clk_s;
			core_oe_n <= oe_n_s;
			core_d    <= d_s;
			pin_q     <= core_q;
			pin_q_oe  <= ~oe_n_s & ~dec.hiz;
		end
	end

////////////////////////////////////////////////////////////////////////////////
	logic                  aw_held_ff;
	logic                  w_held_ff;
	logic [AXI_ADDR_W-1:0] awaddr_ff;
	logic [31:0]           wdata_ff;
	logic                  wstrb0_ff;
	logic [31:0]           rd_word;
	logic                  rd_hit;
	logic                  do_write;

	// Address and data taken in either order, answered one cycle later
	assign s_axi_awready = ~aw_held_ff;
	assign s_axi_wready  = ~w_held_ff;
	assign s_axi_arready = ~s_axi_rvalid;
	assign do_write      = aw_held_ff && w_held_ff && !s_axi_bvalid;

	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			aw_held_ff   <= 1'b0;
			w_held_ff    <= 1'b0;
			awaddr_ff    <= '0;
			wdata_ff     <= 32'h0000_0000;
			wstrb0_ff    <= 1'b0;
			trst_ff      <= 1'b0;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp  <= RESP_OKAY;
		end else begin
			if (s_axi_awvalid && !aw_held_ff) begin
				aw_held_ff <= 1'b1;
				awaddr_ff  <= s_axi_awaddr;
			end
			if (s_axi_wvalid && !w_held_ff) begin
				w_held_ff <= 1'b1;
				wdata_ff  <= s_axi_wdata;
				wstrb0_ff <= s_axi_wstrb[0];
			end
			if (do_write) begin
				aw_held_ff   <= 1'b0;
				w_held_ff    <= 1'b0;
				s_axi_bvalid <= 1'b1;
				s_axi_bresp  <= (awaddr_ff[7:2] <= ADDR_CHAIN_SHD[7:2]) ?
					RESP_OKAY : RESP_SLVERR;
				if (awaddr_ff[7:2] == ADDR_CTRL[7:2] && wstrb0_ff)
					trst_ff <= wdata_ff[0];
			end else if (s_axi_bready) begin
				s_axi_bvalid <= 1'b0;
			end
		end
	end

	// Read decode; unmapped words answer zero with an error
	assign rd_word = (s_axi_araddr[7:2] == ADDR_CTRL[7:2])      ? {31'h0, trst_ff} :
	                 (s_axi_araddr[7:2] == ADDR_STATUS[7:2])    ?
	                     {state_ff, 4'h0, dec.hiz, dec.test, opsel_ff, ir_ff} :
	                 (s_axi_araddr[7:2] == ADDR_CHAIN_SHF[7:2]) ? {14'h0, chain_shift_ff} :
	                 {14'h0, chain_ff};
	assign rd_hit = s_axi_araddr[7:2] <= ADDR_CHAIN_SHD[7:2];

	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			s_axi_rvalid <= 1'b0;
			s_axi_rdata  <= 32'h0000_0000;
			s_axi_rresp  <= RESP_OKAY;
		end else if (s_axi_arvalid && !s_axi_rvalid) begin
			s_axi_rvalid <= 1'b1;
			s_axi_rdata  <= rd_hit ? rd_word : 32'h0000_0000;
			s_axi_rresp  <= rd_hit ? RESP_OKAY : RESP_SLVERR;
		end else if (s_axi_rready) begin
			s_axi_rvalid <= 1'b0;
		end
	end

////////////////////////////////////////////////////////////////////////////////
	// Checks on the scan registers
	chk_ir_reset_value: assert property (@(posedge ref_clk) disable iff (!rst_n)
		state_ff == TAP_RESET |=> ir_ff == IR_RESET)
		else $error("instruction not all ones after reset state");

	chk_opsel_reset_value: assert property (@(posedge ref_clk) disable iff (!rst_n)
		state_ff == TAP_RESET |=> opsel_ff == OPSEL_RESET)
		else $error("select register not 10 after reset state");

	chk_bypass_capture: assert property (@(posedge ref_clk) disable iff (!rst_n)
		rise_cap_dr && dec.sel == SEL_BYPASS |=> bypass_ff == 1'b0)
		else $error("bypass stage did not capture zero");

	chk_ir_capture_pattern: assert property (@(posedge ref_clk) disable iff (!rst_n)
		tck_rise && state_ff == TAP_CAP_IR && !trst_ff |=> ir_shift_ff == IR_CAPTURE)
		else $error("instruction capture pattern wrong");

	chk_chain_reset_hold: assert property (@(posedge ref_clk) disable iff (!rst_n)
		state_ff == TAP_RESET |=> $stable(chain_shift_ff) && $stable(chain_ff))
		else $error("chain changed in reset state");

	chk_opsel_capture_hold: assert property (@(posedge ref_clk) disable iff (!rst_n)
		rise_cap_dr |=> $stable(opsel_shift_ff) && $stable(opsel_ff))
		else $error("select register changed at capture");

	chk_chain_shift_dir: assert property (@(posedge ref_clk) disable iff (!rst_n)
		rise_shf_dr && dec.sel == SEL_CHAIN |=> chain_shift_ff[17] == $past(tdi_s)
		&& chain_shift_ff[16:0] == $past(chain_shift_ff[17:1]))
		else $error("chain shift order wrong");

	chk_test_drive_pins: assert property (@(posedge ref_clk) disable iff (!rst_n)
		dec.test |=> pin_q == $past(chain_ff[7:0]) && core_d == $past(chain_ff[15:8]))
		else $error("test mode not driving from cells");

	chk_float_outputs: assert property (@(posedge ref_clk) disable iff (!rst_n)
		dec.hiz ##1 dec.hiz |-> !pin_q_oe)
		else $error("outputs driven under float instruction");

endmodule // octal_ff_boundary_scan_regs

// ---- verif/tap_host.sv ----
`timescale 1ns/1ps
module tap_host (
	output logic      tck,   // Test clock, still outside frames
	output logic      tms,   // Mode select
	output logic      tdi,   // Serial data out
	input  wire logic tdo,   // Serial data back
	input  wire logic tdo_oe // Serial drive enable
);
	// Parked in reset with the clock low
	initial begin
		tck = 1'b0;
		tms = 1'b1;
		tdi = 1'b0;
	end
	////////////////////////////////////////////////////////////////
	// One clock: set while low, sample at rise; an undriven line reads inverted
	task automatic step(input logic m, input logic d, output logic q);
		tms = m;
		tdi = d;
		#80 tck = 1'b1;
		q = tdo_oe ? tdo : ~tdo;
		#80 tck = 1'b0;
	endtask
	// Mode held high five clocks, then park in idle
	task automatic reset_tap();
		logic q;
		#7;
		repeat (5) step(1'b1, ~tdi, q);
		step(1'b0, ~tdi, q);
	endtask
	// Idle to idle scan, LSB first; idle data toggles so stale values never pass
	task automatic scan(input logic ir, input int n, input logic [17:0] v,
		output logic [17:0] o);
		logic q;
		o = '0;
		#7;
		step(1'b1, ~tdi, q);
		if (ir) step(1'b1, ~tdi, q);
		step(1'b0, ~tdi, q);
		step(1'b0, ~tdi, q);
		for (int i = 0; i < n; i++) begin
			step(i == n - 1, v[i], q);
			o[i] = q;
		end
		step(1'b1, ~tdi, q);
		step(1'b0, ~tdi, q);
	endtask
endmodule // tap_host

// ---- verif/octal_ff_boundary_scan_regs_tb.sv ----
`timescale 1ns/1ps
`define CHK(got, exp, msg) begin \
	total_checks++; \
	if ((got) !== (exp)) begin \
		n_mismatch++; \
		$display("wrong value at %0t ns: %s", $time, msg); \
	end \
end
module octal_ff_boundary_scan_regs_tb
	import scan_regs_pkg::*;
;
	logic        ref_clk, rst_n, pin_clk, pin_oe_n, awvalid, wvalid, bready, arvalid, rready;
	logic [7:0]  pin_d, core_q, awaddr, araddr;
	logic [31:0] wdata, rnd;
	wire logic   tck, tms, tdi, tdo, tdo_oe, core_clk, core_oe_n, pin_q_oe;
	wire logic   awready, wready, bvalid, arready, rvalid;
	wire logic [7:0]  core_d, pin_q;
	wire logic [1:0]  bresp, rresp;
	wire logic [31:0] rdata;
	int          n_mismatch, total_checks, cyc;
	// Run-test opcodes first: they disturb the chain, so a pin capture follows them
	localparam logic [7:0] OPS [18] = '{8'h01, 8'h04, 8'h85, 8'h08, 8'h06, 8'h07, 8'h09,
		8'h0d, 8'h0f, 8'h0e, 8'h02, 8'h83, 8'h0a, 8'h8b, 8'h0c, 8'h00, 8'h7f, 8'hff};
	////////////////////////////////////////////////////////////////
	octal_ff_boundary_scan_regs DUT (.ref_clk(ref_clk), .rst_n(rst_n), .tck(tck), .tms(tms),
		.tdi(tdi), .tdo(tdo), .tdo_oe(tdo_oe), .pin_clk(pin_clk), .pin_oe_n(pin_oe_n),
		.pin_d(pin_d), .core_q(core_q), .core_clk(core_clk), .core_oe_n(core_oe_n),
		.core_d(core_d), .pin_q(pin_q), .pin_q_oe(pin_q_oe), .s_axi_awaddr(awaddr),
		.s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
		.s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
		.s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
		.s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
		.s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready));
	tap_host host (.tck(tck), .tms(tms), .tdi(tdi), .tdo(tdo), .tdo_oe(tdo_oe));
	// 50 MHz system clock
	initial begin
		ref_clk = 1'b0;
		forever #10 ref_clk = ~ref_clk;
	end
	// Hang guard, well above the few thousand cycles the run needs
	always @(posedge ref_clk) begin
		cyc++;
		if (cyc == 40000) begin
			n_mismatch++;
			report_and_stop();
		end
	end
	////////////////////////////////////////////////////////////////
	function automatic logic [31:0] lfsr(input logic [31:0] x);
		return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
	endfunction
	// Expected {kind, test}: kind 0 bypass, 1 chain, 2 select register
	function automatic logic [2:0] mode(input logic [6:0] op);
		case (op)
			7'h00, 7'h03, 7'h0b: return 3'b011;
			7'h02, 7'h0a, 7'h0c: return 3'b010;
			7'h07, 7'h09, 7'h0d: return 3'b001;
			7'h0e:               return 3'b100;
			7'h0f:               return 3'b101;
			default:             return 3'b000;
		endcase
	endfunction
	task automatic report_and_stop();
		if (n_mismatch == 0 && total_checks > 0) $display("SIMULATION PASSED");
		else $display("SIMULATION FAILED");
		$finish;
	endtask
	// Address and data offered together, each released once taken
	task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
		@(posedge ref_clk);
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		do begin
			@(posedge ref_clk);
			if (awready) awvalid <= 1'b0;
			if (wready) wvalid <= 1'b0;
		end while (bvalid !== 1'b1);
		r = bresp;
		bready <= 1'b0;
	endtask
	task automatic axi_rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
		@(posedge ref_clk);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		do begin
			@(posedge ref_clk);
			if (arready) arvalid <= 1'b0;
		end while (rvalid !== 1'b1);
		d = rdata;
		r = rresp;
		rready <= 1'b0;
	endtask
	////////////////////////////////////////////////////////////////
	// Every opcode: instruction scan, status, one data scan, then pins except for 07, 09, 0d and 0f
	initial begin
		logic [7:0]  op;
		logic [2:0]  m;
		logic [17:0] v, o, ex, pv, sh, shd;
		logic [31:0] d;
		logic [1:0]  rs, sel;
		{pin_clk, pin_oe_n, pin_d, core_q, awaddr, araddr, wdata} = '0;
		{awvalid, wvalid, bready, arvalid, rready} = '0;
		rst_n = 1'b0;
		rnd = 32'h162a_aa0c;
		sel = 2'b10;
		{sh, shd} = '0;
		repeat (2) @(posedge ref_clk);
		rst_n <= 1'b1;
		axi_rd(ADDR_STATUS, d, rs);
		`CHK({d[31:16], d[9:0]}, {16'h0001, 2'b10, 8'hff}, "reset status")
		axi_rd(8'h10, d, rs);
		`CHK({rs, d}, {RESP_SLVERR, 32'h0}, "unmapped read")
		axi_wr(8'h10, 32'h1, rs);
		`CHK(rs, RESP_SLVERR, "unmapped write")
		host.reset_tap();
		foreach (OPS[k]) begin
			op = OPS[k];
			m = mode(op[6:0]);
			rnd = lfsr(rnd);
			pv = rnd[17:0];
			if (op[6:0] == 7'h06) pv[16] = 1'b0;
			@(posedge ref_clk);
			{pin_clk, pin_oe_n, pin_d, core_q} <= pv;
			host.scan(1'b1, 8, {10'h0, op}, o);
			`CHK(o[7:0], IR_CAPTURE, "ir capture")
			axi_rd(ADDR_STATUS, d, rs);
			`CHK({d[31:16], d[11:0]}, {16'h0002, op[6:0] == 7'h06, m[0], sel, op}, "mode")
			rnd = lfsr(rnd);
			v = m[1] ? rnd[17:0] : {16'h0, rnd[1:0]};
			ex = m[2] ? {16'h0, sel} : {16'h0, v[0], 1'b0};
			if (m[1]) ex = (op[6:0] == 7'h0c) ? ~shd : (op[3] ? sh : pv);
			host.scan(1'b0, m[1] ? 18 : 2, v, o);
			`CHK(o, ex, "data scan")
			if (m[2]) sel = v[1:0];
			if (m[1]) begin
				sh = v;
				shd = v;
				axi_rd(ADDR_CHAIN_SHD, d, rs);
				`CHK(d[17:0], v, "shadow")
			end
			if (m[1] & m[0]) `CHK({pin_q_oe, pin_q, core_clk, core_oe_n, core_d},
				{~v[16], v[7:0], v[17:16], v[15:8]}, "test drive")
			if (op[6:0] == 7'h06) `CHK(pin_q_oe, 1'b0, "float")
			if (!m[0]) `CHK({pin_q_oe, core_clk, core_oe_n, core_d, pin_q},
				{~pv[16] & (op[6:0] != 7'h06), pv}, "normal path")
		end
		axi_wr(ADDR_CTRL, 32'h1, rs);
		`CHK(rs, RESP_OKAY, "ctrl write")
		axi_rd(ADDR_STATUS, d, rs);
		`CHK({d[31:16], d[9:0]}, {16'h0001, 2'b10, 8'hff}, "ctrl reset")
		axi_rd(ADDR_CHAIN_SHD, d, rs);
		`CHK({rs, d[17:0]}, {RESP_OKAY, shd}, "chain kept")
		axi_wr(ADDR_CTRL, 32'h0, rs);
		report_and_stop();
	end
endmodule // octal_ff_boundary_scan_regs_tb
